// ### core/clk_ctrl_pkg.sv
/*
 * shared constants and types for the power state clock control block.
 * assumes a single 25 mhz clock; slower rates are enables, not clocks.
 */
package clk_ctrl_pkg;

    // power management states, one-hot
    typedef enum logic [4:0] {
        PS_ON      = 5'h01,
        PS_DOZE    = 5'h02,
        PS_SLEEP   = 5'h04,
        PS_SUSPEND = 5'h08,
        PS_OFF     = 5'h10
    } power_state_e;

    // requested state code from the power manager
    localparam logic [2:0] REQ_ON = 3'h0;
    localparam logic [2:0] REQ_DOZE = 3'h1;
    localparam logic [2:0] REQ_SLEEP = 3'h2;
    localparam logic [2:0] REQ_SUSPEND = 3'h3;
    localparam logic [2:0] REQ_OFF = 3'h4;

    // clock rate of the block and of the low frequency enable
    localparam int CLK_HZ = 25000000;
    localparam int LF_HZ = 32768;
    localparam int LF_CYCLES = CLK_HZ / LF_HZ;
    localparam logic [9:0] LF_DIV_LAST = 10'(LF_CYCLES - 1);

    // throttle divider width and value after reset
    localparam int DIV_W = 4;
    localparam logic [3:0] DIV_RESET = 4'h0;
    localparam power_state_e STATE_RESET = PS_ON;

endpackage : clk_ctrl_pkg

// ### core/clk_gate_if.sv
/*
 * enable path from the control core to the pulse divider.
 * assumes both ends run on the same clock.
 */
interface clk_gate_if;
    logic run;
    logic [3:0] divide;
    logic tick;

    modport ctrl (output run, output divide, input tick);
    modport div (input run, input divide, output tick);
endinterface : clk_gate_if

// ### core/rate_divider.sv
/*
 * divider producing one-cycle enable pulses at 1/(divide+1) of clk.
 * assumes divide changes only take effect at a period boundary.
 */
module rate_divider (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control side
    clk_gate_if.div gate
);
    logic [3:0] cnt_q, cnt_d;
    logic [3:0] lim_q, lim_d;
    logic tick_q, tick_d;

    // count; the limit is reloaded only at wrap or while run is low, so no period is cut short
    always_comb
    begin
        cnt_d = cnt_q;
        lim_d = lim_q;
        tick_d = 1'b0;
        if (!gate.run)
        begin
            cnt_d = 4'h0;
            lim_d = gate.divide;
        end
        else if (cnt_q >= lim_q)
        begin
            cnt_d = 4'h0;
            lim_d = gate.divide;
            tick_d = 1'b1;
        end
        else
        begin
            cnt_d = cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_q <= 4'h0;
            lim_q <= clk_ctrl_pkg::DIV_RESET;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            lim_q <= lim_d;
            tick_q <= tick_d;
        end
    end

    assign gate.tick = tick_q;
endmodule : rate_divider

// ### core/power_state_clock_gating.sv
/*
 * power state clock control: turns the power manager's state and the
 * throttle request into oscillator enables and one-cycle clock enables
 * for processor and system logic.
 * assumes clk stands for the high frequency source and all control
 * inputs come from logic on clk; the low frequency tick is an enable.
 */
module power_state_clock_gating (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // power_manager
    input wire logic [2:0] stateReq,
    input wire logic throttleReq,
    input wire logic [3:0] throttleDiv,
    input wire logic cpuStopReq,
    // bus_cycle_generator handshake
    output logic slowReq,
    input wire logic slowAck,
    // clock enables
    output logic hfOscEn,
    output logic cpuClkEn,
    output logic sysClkEn,
    output logic lfTick,
    output logic refreshEn,
    // pin control
    output logic pinOeAllowed,
    output logic pinForceLow,
    // status
    output logic [4:0] powerState
);
    clk_gate_if gate ();

    clk_ctrl_pkg::power_state_e state_q, state_d;
    logic [9:0] lfCnt_q, lfCnt_d;
    logic lfTick_q, lfTick_d;
    logic slowReq_q, slowReq_d;
    logic cpuEn_q, cpuEn_d;
    logic sysEn_q, sysEn_d;
    logic hfOsc_q, hfOsc_d;
    logic refresh_q, refresh_d;
    logic oeAllow_q, oeAllow_d;
    logic forceLow_q, forceLow_d;

    // map a requested code onto a one-hot state
    function automatic clk_ctrl_pkg::power_state_e decode_state(
        input logic [2:0] code
    );
        unique case (code)
            clk_ctrl_pkg::REQ_DOZE: decode_state = clk_ctrl_pkg::PS_DOZE;
            clk_ctrl_pkg::REQ_SLEEP: decode_state = clk_ctrl_pkg::PS_SLEEP;
            clk_ctrl_pkg::REQ_SUSPEND:
                decode_state = clk_ctrl_pkg::PS_SUSPEND;
            clk_ctrl_pkg::REQ_OFF: decode_state = clk_ctrl_pkg::PS_OFF;
            default: decode_state = clk_ctrl_pkg::PS_ON;
        endcase
    endfunction : decode_state

    // off is the only state that parks pins and drops refresh
    function automatic logic is_off(
        input clk_ctrl_pkg::power_state_e st
    );
        is_off = (st == clk_ctrl_pkg::PS_OFF);
    endfunction : is_off

    // state follows the power manager; codes above off read as on
    always_comb
    begin
        state_d = decode_state(stateReq);
    end

    // state register; reset lands in on so memory keeps running
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= clk_ctrl_pkg::STATE_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // level outputs are decoded ahead of the register, so they leave
    // flip-flops in the same cycle as the state itself
    always_comb
    begin
        hfOsc_d = !(state_d == clk_ctrl_pkg::PS_SUSPEND ||
                    is_off(state_d));
        refresh_d = !is_off(state_d);
        oeAllow_d = !is_off(state_d);
        forceLow_d = is_off(state_d);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            hfOsc_q <= 1'b1;
            refresh_q <= 1'b1;
            oeAllow_q <= 1'b1;
            forceLow_q <= 1'b0;
        end
        else
        begin
            hfOsc_q <= hfOsc_d;
            refresh_q <= refresh_d;
            oeAllow_q <= oeAllow_d;
            forceLow_q <= forceLow_d;
        end
    end

    // low frequency enable never depends on the state
    always_comb
    begin
        lfTick_d = 1'b0;
        if (lfCnt_q >= clk_ctrl_pkg::LF_DIV_LAST)
        begin
            lfCnt_d = 10'h000;
            lfTick_d = 1'b1;
        end
        else
        begin
            lfCnt_d = lfCnt_q + 10'h001;
        end
    end

    // low frequency counter is never gated by the power state
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lfCnt_q <= 10'h000;
            lfTick_q <= 1'b0;
        end
        else
        begin
            lfCnt_q <= lfCnt_d;
            lfTick_q <= lfTick_d;
        end
    end

    // the throttle only slows the clocks in sleep and doze
    always_comb
    begin
        slowReq_d = 1'b0;
        gate.run = 1'b0;
        gate.divide = 4'h0;
        unique case (state_q)
            clk_ctrl_pkg::PS_SLEEP, clk_ctrl_pkg::PS_DOZE:
            begin
                slowReq_d = throttleReq;
                gate.run = 1'b1;
                // slow only once the generator agrees
                gate.divide = (throttleReq && slowAck) ? throttleDiv : 4'h0;
            end
            clk_ctrl_pkg::PS_ON:
            begin
                gate.run = 1'b1;
            end
            clk_ctrl_pkg::PS_SUSPEND, clk_ctrl_pkg::PS_OFF:
            begin
                gate.run = 1'b0;
            end
        endcase
    end

    // handshake register toward the bus cycle generator
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            slowReq_q <= 1'b0;
        end
        else
        begin
            slowReq_q <= slowReq_d;
        end
    end

    // registered enables keep every change on a clock boundary
    always_comb
    begin
        sysEn_d = gate.tick;
        cpuEn_d = gate.tick && !cpuStopReq;
    end

    // enables are registered so a gate never opens part way into a cycle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cpuEn_q <= 1'b0;
            sysEn_q <= 1'b0;
        end
        else
        begin
            cpuEn_q <= cpuEn_d;
            sysEn_q <= sysEn_d;
        end
    end

    rate_divider divider (
        .clk(clk),
        .nrst(nrst),
        .gate(gate.div)
    );

    // oscillator halts in suspend and off; pins parked only in off
    assign hfOscEn = hfOsc_q;
    assign refreshEn = refresh_q;
    assign pinOeAllowed = oeAllow_q;
    assign pinForceLow = forceLow_q;

    // pulse and status outputs
    assign lfTick = lfTick_q;
    assign slowReq = slowReq_q;
    assign cpuClkEn = cpuEn_q;
    assign sysClkEn = sysEn_q;
    assign powerState = state_q;
endmodule : power_state_clock_gating

// ### bench/clk_ctrl_checker.sv
/* assertions on the clock control ports.
   assumes one clock and an active low reset. */
module clk_ctrl_checker (
    // watched ports
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] stateReq,
    input wire logic throttleReq,
    input wire logic cpuStopReq,
    input wire logic slowReq,
    input wire logic hfOscEn,
    input wire logic cpuClkEn,
    input wire logic sysClkEn,
    input wire logic lfTick,
    input wire logic refreshEn,
    input wire logic pinOeAllowed,
    input wire logic pinForceLow,
    input wire logic [4:0] powerState
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // three parked cycles drain the pulse pipeline
    sequence parked3;
        (powerState[4:3] != 2'h0) [*3];
    endsequence
    // long enough in on that the closing pulse comes from a wrap made in on
    sequence onLong;
        (powerState == 5'h01) [*5] ##0 sysClkEn;
    endsequence
    off_state_a: assert property (stateReq == 3'h4 |=>
        powerState == 5'h10 && !hfOscEn && !refreshEn && !pinOeAllowed
        && pinForceLow) else $error("off outputs");
    susp_state_a: assert property (stateReq == 3'h3 |=>
        powerState == 5'h08 && !hfOscEn && refreshEn) else $error("susp");
    hf_run_a: assert property (powerState[2:0] != 3'h0 |-> hfOscEn)
        else $error("hf osc");
    no_pulse_a: assert property (parked3 |-> !sysClkEn && !cpuClkEn)
        else $error("pulse parked");
    lf_period_a: assert property (lfTick |-> ##[762:762] lfTick)
        else $error("lf period");
    slow_req_a: assert property (throttleReq && powerState[2:1] != 2'h0
        && stateReq inside {3'h1, 3'h2} |=> slowReq) else $error("slow");
    slow_idle_a: assert property (!throttleReq |=> !slowReq)
        else $error("slow idle");
    cpu_gate_a: assert property (cpuClkEn == (sysClkEn &&
        !$past(cpuStopReq))) else $error("cpu gate");
    full_rate_a: assert property (onLong |=> sysClkEn)
        else $error("full rate");
endmodule : clk_ctrl_checker

// ### bench/bus_cycle_gen_model.sv
/* bus cycle generator stand-in: agrees to slow after LAT cycles.
   assumes the block's clock. */
module bus_cycle_gen_model #(
    parameter int LAT = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // handshake
    input wire logic slowReq,
    output logic slowAck
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] seen_q;
    // delay line; a late ack shows the block waits for agreement
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
            seen_q <= 8'h00;
        else
            seen_q <= {seen_q[6:0], slowReq};
    assign slowAck = seen_q[LAT-1];
endmodule : bus_cycle_gen_model

// ### bench/power_state_clock_gating_tb.sv
/* self-checking bench for the clock control block.
   assumes the design, its package and the partner model. */
module power_state_clock_gating_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, nrst = 0, throttleReq = 0, cpuStopReq = 0;
    logic [2:0] stateReq = 3'h0;
    logic [3:0] throttleDiv = 4'h0;
    logic slowReq, slowAck, hfOscEn, cpuClkEn, sysClkEn, lfTick;
    logic refreshEn, pinOeAllowed, pinForceLow;
    logic [4:0] powerState;
    logic [3:0] flags;
    int miscompares = 0, checksDone = 0, c;
    // code, state, {hf, refresh, oe, low}
    logic [11:0] rows [6] = '{{3'h1, 5'h02, 4'he}, {3'h2, 5'h04, 4'he},
        {3'h3, 5'h08, 4'h6}, {3'h4, 5'h10, 4'h1}, {3'h7, 5'h01, 4'he},
        {3'h0, 5'h01, 4'he}};
    always #20 clk = ~clk;
    power_state_clock_gating power_state_clock_gating_i (.clk(clk),
        .nrst(nrst), .stateReq(stateReq), .throttleReq(throttleReq),
        .throttleDiv(throttleDiv), .cpuStopReq(cpuStopReq),
        .slowReq(slowReq), .slowAck(slowAck), .hfOscEn(hfOscEn),
        .cpuClkEn(cpuClkEn), .sysClkEn(sysClkEn), .lfTick(lfTick),
        .refreshEn(refreshEn), .pinOeAllowed(pinOeAllowed),
        .pinForceLow(pinForceLow), .powerState(powerState));
    assign flags = {hfOscEn, refreshEn, pinOeAllowed, pinForceLow};
    bus_cycle_gen_model bus_cycle_gen_model_i (.clk(clk), .nrst(nrst),
        .slowReq(slowReq), .slowAck(slowAck));
    task results;
        $display("checks %0d errors %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    task chk(string n, logic [7:0] e, logic [7:0] g);
        checksDone++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // cycles to the next pulse; a lost pulse ends the run
    task gap(bit lf);
        c = 0;
        do
        begin
            tick(1);
            c++;
        end while (!(lf ? lfTick : sysClkEn) && c < 900);
        if (c == 900)
        begin
            miscompares++;
            results();
        end
    endtask : gap
    initial
    begin
        tick(8);
        nrst = 1;
        chk("rst", 8'h01, 8'(powerState));
        foreach (rows[i])
        begin
            stateReq = rows[i][11:9];
            tick(2);
            chk("st", 8'(rows[i][8:4]), 8'(powerState));
            chk("fl", 8'(rows[i][3:0]), 8'(flags));
        end
        gap(0);
        gap(0);
        chk("on", 8'h01, 8'(c));
        throttleReq = 1;
        tick(3);
        chk("rq", 8'h00, 8'(slowReq));
        stateReq = 3'h2;
        throttleDiv = 4'h3;
        tick(40);
        chk("rq1", 8'h01, 8'(slowReq));
        gap(0);
        gap(0);
        chk("sl", 8'h04, 8'(c));
        chk("cpu1", 8'h01, 8'(cpuClkEn));
        cpuStopReq = 1;
        gap(0);
        tick(1);
        gap(0);
        chk("cpu", 8'h00, 8'(cpuClkEn));
        stateReq = 3'h4;
        gap(1);
        gap(1);
        chk("lf", 8'(762 - 512), 8'(c - 512));
        nrst = 0;
        tick(2);
        chk("rr", 8'h01, 8'(powerState));
        results();
    end
endmodule : power_state_clock_gating_tb
bind power_state_clock_gating clk_ctrl_checker clk_ctrl_checker_i (
    .clk(clk), .nrst(nrst), .stateReq(stateReq),
    .throttleReq(throttleReq), .cpuStopReq(cpuStopReq),
    .slowReq(slowReq), .hfOscEn(hfOscEn), .cpuClkEn(cpuClkEn),
    .sysClkEn(sysClkEn), .lfTick(lfTick), .refreshEn(refreshEn),
    .pinOeAllowed(pinOeAllowed), .pinForceLow(pinForceLow),
    .powerState(powerState));
